/* rtl/acrb_regs.svh */
`ifndef ACRB_REGS_SVH
`define ACRB_REGS_SVH

// register offsets
`define ACRB_OFS_SETUP      8'h06
`define ACRB_OFS_THR_HIGH   8'h07
`define ACRB_OFS_THR_LOW    8'h08
`define ACRB_OFS_CH0_SETUP  8'h09
`define ACRB_OFS_IRQ_STATUS 8'h10
`define ACRB_OFS_IRQ_MASK   8'h11
`define ACRB_OFS_DET_STATUS 8'h12

// reset values
`define ACRB_RST_SETUP      16'h0600
`define ACRB_RST_THR_HIGH   16'h0000
`define ACRB_RST_THR_LOW    16'h0000
`define ACRB_RST_CH0_SETUP  16'h0000
`define ACRB_RST_IRQ        2'h0

// chop_and_detect_setup fields
`define ACRB_RSVD_MSB       15
`define ACRB_RSVD_LSB       13
`define ACRB_DLY_MSB        12
`define ACRB_DLY_LSB        9
`define ACRB_CHOP_EN_BIT    8
`define ACRB_ALLCH_BIT      7
`define ACRB_NUM_MSB        6
`define ACRB_NUM_LSB        4
`define ACRB_LEN_MSB        3
`define ACRB_LEN_LSB        1
`define ACRB_DET_EN_BIT     0

// threshold and channel zero fields
`define ACRB_THL_MSB        15
`define ACRB_THL_LSB        8
`define ACRB_DCB_MSB        3
`define ACRB_DCB_LSB        0
`define ACRB_PH_MSB         15
`define ACRB_PH_LSB         6
`define ACRB_DCOFF_BIT      2
`define ACRB_MUX_MSB        1
`define ACRB_MUX_LSB        0

// interrupt status bits
`define ACRB_IRQ_DETECT     0
`define ACRB_IRQ_WINDOW     1

// measurement window lengths in conversions
`define ACRB_WIN_LEN0       12'h080
`define ACRB_WIN_LEN1       12'h100
`define ACRB_WIN_LEN2       12'h200
`define ACRB_WIN_LEN3       12'h300
`define ACRB_WIN_LEN4       12'h500
`define ACRB_WIN_LEN5       12'h700
`define ACRB_WIN_LEN6       12'ha00
`define ACRB_WIN_LEN7       12'he00

`endif

/* rtl/acrb_pkg.sv */
package acrb_pkg;

  typedef enum logic [1:0] {
    ACRB_IN_PAIR,
    ACRB_IN_SHORTED,
    ACRB_IN_POS_TEST,
    ACRB_IN_NEG_TEST
  } acrb_in_sel_t;

  typedef struct packed {
    logic [2:0] reserved_bits;
    logic [3:0] chop_settle_delay;
    logic       chop_enable;
    logic       detect_all_channels;
    logic [2:0] detect_exceed_count;
    logic [2:0] detect_window_length;
    logic       detect_mode_enable;
  } acrb_setup_t;

  typedef struct packed {
    logic [9:0]   channel_zero_phase_delay;
    logic         channel_zero_dc_removal_off;
    acrb_in_sel_t channel_zero_input_select;
  } acrb_ch0_t;

  typedef struct packed {
    acrb_setup_t setup;
    logic [23:0] threshold;
    logic [3:0]  dc_removal_setting;
    acrb_ch0_t   ch0;
  } acrb_cfg_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } acrb_req_t;

  typedef struct packed {
    acrb_cfg_t   cfg;
    logic [16:0] chop_delay_cycles;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [15:0] rd_data;
  } acrb_state_t;

endpackage : acrb_pkg

/* rtl/acrb_detect.sv */
`timescale 1ns/10ps
`include "acrb_regs.svh"

module acrb_detect #(
  parameter int NCH = 6
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  // settings
  input  wire logic                  enable,
  input  wire logic                  all_ch,
  input  wire logic [2:0]            exceed_code,
  input  wire logic [2:0]            len_code,
  input  wire logic [23:0]           threshold,
  // conversions
  input  wire logic                  sample_valid,
  input  wire logic [NCH-1:0][23:0]  samples,
  // results
  output logic                       detect_pulse,
  output logic                       window_pulse,
  output logic                       active,
  output logic                       fired
);

  typedef struct packed {
    logic [11:0]          conv;
    logic [NCH-1:0][7:0]  hits;
    logic                 fired;
    logic                 det;
    logic                 win;
    logic                 active;
  } acrb_det_state_t;

  acrb_det_state_t st;
  acrb_det_state_t next_st;
  logic [NCH-1:0]  exceed;

  function automatic logic [11:0] window_len(input logic [2:0] code);
    unique case (code)
      3'h0: return `ACRB_WIN_LEN0;
      3'h1: return `ACRB_WIN_LEN1;
      3'h2: return `ACRB_WIN_LEN2;
      3'h3: return `ACRB_WIN_LEN3;
      3'h4: return `ACRB_WIN_LEN4;
      3'h5: return `ACRB_WIN_LEN5;
      3'h6: return `ACRB_WIN_LEN6;
      3'h7: return `ACRB_WIN_LEN7;
    endcase
  endfunction : window_len

  function automatic logic [7:0] hit_target(input logic [2:0] code);
    return 8'(8'h01 << code);
  endfunction : hit_target

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_cmp
      assign exceed[g] = $signed(samples[g]) > $signed(threshold);
    end
  endgenerate

  always_comb begin
    logic [NCH-1:0] reach;
    logic           qual;
    reach = '0;
    qual = 1'b0;
    next_st = st;
    next_st.det = 1'b0;
    next_st.win = 1'b0;
    next_st.active = enable;
    if (!enable) begin
      next_st.conv = '0;
      next_st.hits = '0;
      next_st.fired = 1'b0;
    end else if (sample_valid) begin
      for (int i = 0; i < NCH; i++) begin
        // saturate at the target so a long window cannot wrap
        if (exceed[i] && (st.hits[i] < hit_target(exceed_code))) begin
          next_st.hits[i] = 8'(st.hits[i] + 8'h01);
        end
        reach[i] = next_st.hits[i] >= hit_target(exceed_code);
      end
      qual = all_ch ? &reach : |reach;
      if (qual && !st.fired) begin
        next_st.det = 1'b1;
        next_st.fired = 1'b1;
      end
      if (st.conv >= 12'(window_len(len_code) - 12'h001)) begin
        next_st.win = 1'b1;
        next_st.conv = '0;
        next_st.hits = '0;
        next_st.fired = 1'b0;
      end else begin
        next_st.conv = 12'(st.conv + 12'h001);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign detect_pulse = st.det;
  assign window_pulse = st.win;
  assign active       = st.active;
  assign fired        = st.fired;

endmodule : acrb_detect

/* rtl/acrb_top.sv */
`timescale 1ns/10ps
`include "acrb_regs.svh"

module acrb_top
  import acrb_pkg::*;
#(
  parameter int NCH = 6
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  // register port
  input  wire acrb_req_t             req,
  output logic [15:0]                rd_data,
  // conversion results
  input  wire logic                  sample_valid,
  input  wire logic [NCH-1:0][23:0]  samples,
  // configuration to the converter
  output acrb_cfg_t                  cfg,
  output logic [16:0]                chop_delay_cycles,
  // events
  output logic                       detect_flag,
  output logic                       irq
);

  acrb_state_t st;
  acrb_state_t next_st;

  logic det_pulse;
  logic win_pulse;
  logic det_active;
  logic det_fired;
  logic [1:0] irq_events;

  // write decode is shared by the store path and the clear path
  function automatic logic hit(input acrb_req_t r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction : hit

  function automatic acrb_setup_t unpack_setup(input logic [15:0] w);
    acrb_setup_t s;
    s.reserved_bits        = w[`ACRB_RSVD_MSB:`ACRB_RSVD_LSB];
    s.chop_settle_delay    = w[`ACRB_DLY_MSB:`ACRB_DLY_LSB];
    s.chop_enable          = w[`ACRB_CHOP_EN_BIT];
    s.detect_all_channels  = w[`ACRB_ALLCH_BIT];
    s.detect_exceed_count  = w[`ACRB_NUM_MSB:`ACRB_NUM_LSB];
    s.detect_window_length = w[`ACRB_LEN_MSB:`ACRB_LEN_LSB];
    s.detect_mode_enable   = w[`ACRB_DET_EN_BIT];
    return s;
  endfunction : unpack_setup

  function automatic acrb_ch0_t unpack_ch0(input logic [15:0] w);
    acrb_ch0_t c;
    c.channel_zero_phase_delay    = w[`ACRB_PH_MSB:`ACRB_PH_LSB];
    c.channel_zero_dc_removal_off = w[`ACRB_DCOFF_BIT];
    c.channel_zero_input_select   =
      acrb_in_sel_t'(w[`ACRB_MUX_MSB:`ACRB_MUX_LSB]);
    return c;
  endfunction : unpack_ch0

  // 2^(n+1): code 15 needs the 17th bit for 65536
  function automatic logic [16:0] delay_of(input logic [3:0] code);
    return 17'(17'h00002 << code);
  endfunction : delay_of

  // reset image of every register, built from the word-level defaults
  localparam logic [15:0] RST_SETUP   = `ACRB_RST_SETUP;
  localparam logic [15:0] RST_THR_LOW = `ACRB_RST_THR_LOW;
  localparam logic [15:0] RST_CH0     = `ACRB_RST_CH0_SETUP;
  localparam acrb_state_t RST_ST = '{
    cfg: '{
      setup:              acrb_setup_t'(RST_SETUP),
      threshold:          {`ACRB_RST_THR_HIGH, RST_THR_LOW[15:8]},
      dc_removal_setting: RST_THR_LOW[`ACRB_DCB_MSB:`ACRB_DCB_LSB],
      ch0: acrb_ch0_t'({RST_CH0[`ACRB_PH_MSB:`ACRB_PH_LSB],
                        RST_CH0[`ACRB_DCOFF_BIT:`ACRB_MUX_LSB]})
    },
    chop_delay_cycles:
      17'(17'h00002 << RST_SETUP[`ACRB_DLY_MSB:`ACRB_DLY_LSB]),
    irq_status: `ACRB_RST_IRQ,
    irq_mask:   `ACRB_RST_IRQ,
    rd_data:    16'h0000
  };

  always_comb begin
    logic [15:0] rword;
    rword = 16'h0000;
    next_st = st;

    // configuration stores
    if (hit(req, `ACRB_OFS_SETUP)) begin
      next_st.cfg.setup = unpack_setup(req.wdata);
    end
    if (hit(req, `ACRB_OFS_THR_HIGH)) begin
      next_st.cfg.threshold[23:8] = req.wdata;
    end
    if (hit(req, `ACRB_OFS_THR_LOW)) begin
      next_st.cfg.threshold[7:0] =
        req.wdata[`ACRB_THL_MSB:`ACRB_THL_LSB];
      next_st.cfg.dc_removal_setting =
        req.wdata[`ACRB_DCB_MSB:`ACRB_DCB_LSB];
    end
    if (hit(req, `ACRB_OFS_CH0_SETUP)) begin
      next_st.cfg.ch0 = unpack_ch0(req.wdata);
    end

    // decoded delay follows the stored field one cycle later
    next_st.chop_delay_cycles =
      delay_of(st.cfg.setup.chop_settle_delay);

    // interrupt mask
    if (hit(req, `ACRB_OFS_IRQ_MASK)) begin
      next_st.irq_mask = req.wdata[1:0];
    end

    // sticky status: write one clears, a new event in the same cycle wins
    if (hit(req, `ACRB_OFS_IRQ_STATUS)) begin
      next_st.irq_status = st.irq_status & ~req.wdata[1:0];
    end
    next_st.irq_status = next_st.irq_status | irq_events;

    // read path, answered in the following cycle only
    if (req.rd) begin
      unique case (req.addr)
        `ACRB_OFS_SETUP: begin
          rword = {st.cfg.setup.reserved_bits,
                   st.cfg.setup.chop_settle_delay,
                   st.cfg.setup.chop_enable,
                   st.cfg.setup.detect_all_channels,
                   st.cfg.setup.detect_exceed_count,
                   st.cfg.setup.detect_window_length,
                   st.cfg.setup.detect_mode_enable};
        end
        `ACRB_OFS_THR_HIGH: begin
          rword = st.cfg.threshold[23:8];
        end
        `ACRB_OFS_THR_LOW: begin
          rword = {st.cfg.threshold[7:0], 4'h0,
                   st.cfg.dc_removal_setting};
        end
        `ACRB_OFS_CH0_SETUP: begin
          rword = {st.cfg.ch0.channel_zero_phase_delay, 3'h0,
                   st.cfg.ch0.channel_zero_dc_removal_off,
                   st.cfg.ch0.channel_zero_input_select};
        end
        `ACRB_OFS_IRQ_STATUS: begin
          rword = {14'h0000, st.irq_status};
        end
        `ACRB_OFS_IRQ_MASK: begin
          rword = {14'h0000, st.irq_mask};
        end
        `ACRB_OFS_DET_STATUS: begin
          rword = {14'h0000, det_fired, det_active};
        end
        default: begin
          rword = 16'h0000;
        end
      endcase
    end
    next_st.rd_data = rword;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= RST_ST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // current detect engine
  acrb_detect #(
    .NCH (NCH)
  ) u_detect (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .ce           (ce),
    .enable       (st.cfg.setup.detect_mode_enable),
    .all_ch       (st.cfg.setup.detect_all_channels),
    .exceed_code  (st.cfg.setup.detect_exceed_count),
    .len_code     (st.cfg.setup.detect_window_length),
    .threshold    (st.cfg.threshold),
    .sample_valid (sample_valid),
    .samples      (samples),
    .detect_pulse (det_pulse),
    .window_pulse (win_pulse),
    .active       (det_active),
    .fired        (det_fired)
  );

  always_comb begin
    irq_events = 2'h0;
    irq_events[`ACRB_IRQ_DETECT] = det_pulse;
    irq_events[`ACRB_IRQ_WINDOW] = win_pulse;
  end

  assign rd_data           = st.rd_data;
  assign cfg               = st.cfg;
  assign chop_delay_cycles = st.chop_delay_cycles;
  assign detect_flag       = det_pulse;
  // level output, drops as soon as software clears or masks the bit
  assign irq               = |(st.irq_status & st.irq_mask);

endmodule : acrb_top

/* dv/acrb_top_sva.sv */
`timescale 1ns/10ps
module acrb_top_sva
  import acrb_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        ce,
  // register port
  input wire acrb_req_t   req,
  input wire logic [15:0] rd_data,
  // outputs
  input wire acrb_cfg_t   cfg,
  input wire logic [16:0] chop_delay_cycles,
  input wire logic        detect_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence wr_at(logic [7:0] a);
    ce && req.wr && req.addr == a;
  endsequence
  sequence rd_at(logic [7:0] a);
    ce && req.rd && req.addr == a;
  endsequence

  setup_store_a: assert property (
    wr_at(8'h06) |=> cfg.setup == $past(req.wdata))
    else $error("setup word not stored");
  thr_high_store_a: assert property (
    wr_at(8'h07) |=> cfg.threshold[23:8] == $past(req.wdata))
    else $error("upper threshold word not stored");
  thr_low_store_a: assert property (
    wr_at(8'h08) |=> {cfg.threshold[7:0], cfg.dc_removal_setting} ==
      {$past(req.wdata[15:8]), $past(req.wdata[3:0])})
    else $error("lower threshold word not stored");
  ch0_store_a: assert property (
    wr_at(8'h09) |=> cfg.ch0 ==
      {$past(req.wdata[15:6]), $past(req.wdata[2:0])})
    else $error("channel zero word not stored");
  cfg_hold_a: assert property (
    !(ce && req.wr) |=> $stable(cfg))
    else $error("configuration changed without a write");
  chop_decode_a: assert property (
    $past(ce) |-> chop_delay_cycles ==
      (17'h00002 << $past(cfg.setup.chop_settle_delay)))
    else $error("chop delay decode wrong");
  thr_readback_a: assert property (
    rd_at(8'h07) |=> rd_data == $past(cfg.threshold[23:8]))
    else $error("upper threshold read back wrong");
  low_ro_zero_a: assert property (
    rd_at(8'h08) |=> rd_data[7:4] == 4'h0)
    else $error("threshold low reserved bits not zero");
  ch0_ro_zero_a: assert property (
    rd_at(8'h09) |=> rd_data[5:3] == 3'h0)
    else $error("channel zero reserved bits not zero");
  detect_off_a: assert property (
    !cfg.setup.detect_mode_enable [*4] |=> !detect_flag)
    else $error("detection while disabled");
endmodule : acrb_top_sva

bind acrb_top acrb_top_sva acrb_top_sva_i (
  .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .req(req),
  .rd_data(rd_data), .cfg(cfg), .chop_delay_cycles(chop_delay_cycles),
  .detect_flag(detect_flag));

/* dv/adc_config_register_bank_bench.sv */
`timescale 1ns/10ps
module adc_config_register_bank_bench
  import acrb_pkg::*;
;
  logic             sys_clk = 1'b0;
  logic             resetn = 1'b0;
  logic             ce = 1'b1;
  acrb_req_t        req = '0;
  logic             sample_valid = 1'b0;
  logic [1:0][23:0] samples = '0;
  logic [15:0]      rd_data;
  acrb_cfg_t        cfg;
  logic [16:0]      chop_delay_cycles;
  logic             detect_flag;
  logic             irq;
  int               fail_count = 0;
  int               compares = 0;
  logic             f;

  always #20 sys_clk = ~sys_clk;

  acrb_top #(.NCH(2)) acrb_top_i (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .req(req),
    .rd_data(rd_data), .sample_valid(sample_valid), .samples(samples),
    .cfg(cfg), .chop_delay_cycles(chop_delay_cycles),
    .detect_flag(detect_flag), .irq(irq));

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
    #1;
  endtask : wr

  task automatic rc(string n, logic [7:0] a, logic [15:0] e);
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk);
    req <= '0;
    #1 chk(n, rd_data, e);
  endtask : rc

  // flag is caught in any of the three cycles after the sample edge
  task automatic send(logic [23:0] s0, logic [23:0] s1);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    samples <= {s1, s0};
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    #1 f = (detect_flag === 1'b1);
    repeat (2) begin
      @(posedge sys_clk);
      #1 f = f | (detect_flag === 1'b1);
    end
  endtask : send

  task automatic t_reset();
    rc("setup", 8'h06, 16'h0600);
    rc("thr_high", 8'h07, 16'h0000);
    rc("thr_low", 8'h08, 16'h0000);
    rc("ch0", 8'h09, 16'h0000);
    rc("irq_status", 8'h10, 16'h0000);
    rc("irq_mask", 8'h11, 16'h0000);
    rc("unmapped", 8'h3f, 16'h0000);
    chk("chop_cycles", chop_delay_cycles, 16);
    chk("irq", irq, 1'b0);
  endtask : t_reset

  task automatic t_fields();
    wr(8'h06, 16'h1ffe);
    rc("setup", 8'h06, 16'h1ffe);
    for (int n = 0; n < 16; n++) begin
      wr(8'h06, 16'(n) << 9);
      @(posedge sys_clk);
      #1 chk("chop_cycles", chop_delay_cycles, 2 << n);
    end
    wr(8'h07, 16'ha5c3);
    wr(8'h08, 16'hffff);
    wr(8'h09, 16'hffff);
    rc("thr_high", 8'h07, 16'ha5c3);
    rc("thr_low", 8'h08, 16'hff0f);
    rc("ch0", 8'h09, 16'hffc7);
    chk("threshold", cfg.threshold, 24'ha5c3ff);
    for (int k = 0; k < 4; k++) begin
      wr(8'h09, 16'(k));
      chk("input_select", cfg.ch0.channel_zero_input_select, k);
    end
    // neither a stray address nor a frozen clock enable may disturb it
    wr(8'h3f, 16'h0000);
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(8'h07, 16'h1234);
    ce <= 1'b1;
    rc("thr_high", 8'h07, 16'ha5c3);
  endtask : t_fields

  task automatic t_detect();
    wr(8'h07, 16'h0000);
    wr(8'h08, 16'h6400);
    wr(8'h11, 16'h0001);
    wr(8'h06, 16'h0611);
    send(24'd101, 24'd0);
    chk("first_hit", f, 1'b0);
    send(24'd100, 24'd0);
    chk("equal_value", f, 1'b0);
    send(24'd101, 24'd0);
    chk("second_hit", f, 1'b1);
    chk("irq_set", irq, 1'b1);
    rc("irq_status", 8'h10, 16'h0001);
    wr(8'h10, 16'h0001);
    chk("irq_clear", irq, 1'b0);
    repeat (125) send(24'd0, 24'd0);
    rc("window_end", 8'h10, 16'h0002);
    chk("irq_masked", irq, 1'b0);
    wr(8'h11, 16'h0003);
    chk("irq_unmask", irq, 1'b1);
    wr(8'h10, 16'h0002);
    chk("irq_clear2", irq, 1'b0);
    wr(8'h06, 16'h0691);
    send(24'd200, 24'd0);
    send(24'd200, 24'd0);
    chk("all_one_ch", f, 1'b0);
    send(24'd0, 24'd200);
    send(24'd0, 24'd200);
    chk("all_both", f, 1'b1);
    rc("det_status", 8'h12, 16'h0003);
    wr(8'h06, 16'h0600);
    send(24'd200, 24'd200);
    send(24'd200, 24'd200);
    chk("disabled", f, 1'b0);
    rc("det_off", 8'h12, 16'h0000);
  endtask : t_detect

  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_fields();
    t_detect();
    // a reset in mid-run must bring every field back to its default
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    wrap_up();
  end

  // about fifteen times the expected run
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
endmodule : adc_config_register_bank_bench
